// [power_saving_mode_control_tb_top.sv]
// Testbench of the power-saving controller: APB master, mode scenarios, verdict
`timescale 1ns/1ps
`include "psm_cfg.svh"
module power_saving_mode_control_tb_top import psm_pkg::*;;
  logic        clk, rstn, psel, penable, pwrite, clr;          // Bench-driven controls
  logic [11:0] paddr;                                          // APB address
  logic [31:0] pwdata, prdata;                                 // APB data
  logic        pready, pslverr, osc, pll, core, per, time_interval_counter;      // Design outputs
  logic        ale_l, ale_f, ps_l, ps_f, port_h, dac_h, dac_oe, resume;
  psm_wake_t   raise, irq;                                     // Wake stimulus and levels
  logic [9:0]  pv;                                             // Pin and clock view
  int          errors, total_checks;                           // Counters
  assign pv = {osc, core, per, time_interval_counter, ale_f, ale_l, ps_f, ps_l, port_h, dac_oe};

  psm_ctrl u_dut (.SYS_CLK_I(clk), .RSTN_I(rstn), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .TIC_IRQ_I(irq.time_interval_counter), .SERIAL_IRQ_I(irq.serial),
    .EXT_EXTERNAL_INTERRUPT_ZERO_IRQ_I(irq.ext0), .ANY_EN_IRQ_I(irq.any_en), .OSC_EN_O(osc), .PLL_EN_O(pll),
    .CORE_CLK_EN_O(core), .PERIPH_CLK_EN_O(per), .TIC_CLK_EN_O(time_interval_counter), .ALE_LEVEL_O(ale_l),
    .ALE_FORCE_O(ale_f), .PROG_STROBE_LEVEL_O(ps_l), .PROG_STROBE_FORCE_O(ps_f),
    .PORT_HOLD_O(port_h), .DAC_HOLD_O(dac_h), .DAC_OE_O(dac_oe), .RESUME_O(resume));
  psm_wake_model u_src (.clk_i(clk), .rstn_i(rstn), .raise_i(raise), .clr_i(clr),
    .resume_i(resume), .irq_o(irq));

  // Free-running system clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Compare and count
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // One APB transfer; answer and read data are taken at the ready edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && ++n < 50);
    if (n >= 50) errors++;
    err = pslverr;
    rd  = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r; logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task rdchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r; logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, r, exp);
  endtask : rdchk
  task step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : step
  // Raise a source for one cycle; the model keeps it pending
  task pulse(input psm_wake_t w);
    @(posedge clk); raise <= w;
    @(posedge clk); raise <= '0;
  endtask : pulse
  // Bounded wait for the resume pulse, then normal-mode pins
  task woke(input string nm);
    int n;
    n = 0;
    do step(1); while (resume !== 1'b1 && ++n < 20);
    chk(nm, resume, 1'b1);
    step(1);
    chk("normal", {osc, pll, core, per, time_interval_counter, ale_f, ps_f, port_h, dac_h, dac_oe, resume},
        11'h7C2);
    rdchk("status_n", `PSM_STATUS_ADDR, 32'h1);
  endtask : woke
  task t_idle;
    wr(`PSM_PWR_CTRL_ADDR, 32'h1);
    step(2);
    chk("idle_pins", pv, 10'h2FF);
    chk("dac_hold", dac_h, 1'b1);
    rdchk("status_i", `PSM_STATUS_ADDR, 32'h2);
    pulse('{time_interval_counter: 1'b0, serial: 1'b0, ext0: 1'b0, any_en: 1'b1});
    woke("idle_wake");
  endtask : t_idle
  task t_pdown;
    for (int o = 0; o < 2; o++) begin
      wr(`PSM_PLL_CTRL_ADDR, 32'(o));
      wr(`PSM_PWR_CTRL_ADDR, 32'h2);
      step(2);
      chk("pd_pins", pv, {~1'(o), 2'b00, ~1'(o), 6'h2A});
      chk("pll", pll, 1'b0);
      rdchk("status_p", `PSM_STATUS_ADDR, 32'h4);
      pulse('{time_interval_counter: 1'b1, serial: 1'b0, ext0: 1'b0, any_en: 1'b0});
      woke("tic_wake");
    end
  endtask : t_pdown
  // Serial and external zero wake only once their enable bit is set
  task t_gate;
    psm_wake_t w;
    for (int i = 0; i < 2; i++) begin
      w = i ? psm_wake_t'(4'h2) : psm_wake_t'(4'h4);
      wr(`PSM_PWR_CTRL_ADDR, 32'h2);
      pulse(w);
      step(8);
      rdchk("stay_pd", `PSM_STATUS_ADDR, 32'h4);
      @(posedge clk); clr <= 1'b1;
      @(posedge clk); clr <= 1'b0;
      wr(`PSM_PWR_CTRL_ADDR, 32'h2 | (32'h1 << (i ? `PSM_EXTERNAL_INTERRUPT_ZERO_WAKE_BIT : `PSM_SER_WAKE_BIT)));
      step(2);
      pulse(w);
      woke("en_wake");
    end
  endtask : t_gate
  task t_reset;
    logic [31:0] r; logic e;
    wr(`PSM_PLL_CTRL_ADDR, 32'h1);
    wr(`PSM_PWR_CTRL_ADDR, 32'h2);
    step(2);
    @(posedge clk); rstn <= 1'b0;
    @(posedge clk); rstn <= 1'b1;
    rdchk("pwr_rst", `PSM_PWR_CTRL_ADDR, 32'h0);
    rdchk("pll_rst", `PSM_PLL_CTRL_ADDR, 32'h0);
    rdchk("status_r", `PSM_STATUS_ADDR, 32'h1);
    apb(1'b1, 12'h00C, 32'hFFFFFFFF, r, e);
    chk("unmapped_err", e, 1'b1);
    rdchk("unmapped_rd", 12'h00C, 32'h0);
  endtask : t_reset
  task results;
    $display("Checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results
  // Main sequence after a six-cycle reset
  initial begin
    {rstn, psel, penable, pwrite, clr, paddr, pwdata, raise} = '0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    t_idle();
    t_pdown();
    t_gate();
    t_reset();
    results();
  end
  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    results();
  end
endmodule : power_saving_mode_control_tb_top

// [psm_cfg.svh]
// Register offsets, field positions, reset values and unmapped read value of the power-saving controller
`ifndef PSM_CFG_SVH
`define PSM_CFG_SVH
// Byte addresses on the APB bus
`define PSM_PWR_CTRL_ADDR   12'h000
`define PSM_PLL_CTRL_ADDR   12'h004
`define PSM_STATUS_ADDR     12'h008
// Power control register fields
`define PSM_IDLE_BIT        0
`define PSM_PDOWN_BIT       1
`define PSM_SER_WAKE_BIT    2
`define PSM_EXTERNAL_INTERRUPT_ZERO_WAKE_BIT   3
// PLL control register fields
`define PSM_OSCILLATOR_POWERDOWN_BIT_BIT      0
// Reset values
`define PSM_PWR_CTRL_RST    4'h0
`define PSM_PLL_CTRL_RST    1'h0
// Unmapped read value
`define PSM_RD_NONE         32'h00000000
`endif

// [psm_ctrl.sv]
// Power-saving mode controller: normal, idle and power-down with clock and strobe gating
//
// Contract
// - Idle bit enters idle, powerdown bit enters powerdown
// - Idle: oscillator runs, core clock stops, peripherals run
// - Idle: core state preserved by holding core clock
// - Idle: ports and DAC hold, strobes driven high
// - Any enabled interrupt or reset ends idle
// - Powerdown: PLL, core, peripherals off except interval counter
// - Oscillator powerdown bit selects oscillator halt in powerdown
// - Interval counter keeps its clock in powerdown only while the oscillator powerdown bit is clear
// - Powerdown: ports hold, DAC floats, strobes low
// - Reset returns to normal with defaults
// - Interval counter interrupt ends powerdown, resumes after
// - Serial interrupt wakes powerdown only if enabled
// - External interrupt zero wakes only if enabled
`timescale 1ns/1ps
`include "psm_cfg.svh"

module psm_ctrl
  import psm_pkg::*;
(
  // Clock and reset
  input  wire logic        SYS_CLK_I,
  input  wire logic        RSTN_I,
  // APB slave
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [11:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic [31:0]      PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  // Wake-up sources, asynchronous
  input  wire logic        TIC_IRQ_I,
  input  wire logic        SERIAL_IRQ_I,
  input  wire logic        EXT_EXTERNAL_INTERRUPT_ZERO_IRQ_I,
  input  wire logic        ANY_EN_IRQ_I,
  // Clock gating
  output logic             OSC_EN_O,
  output logic             PLL_EN_O,
  output logic             CORE_CLK_EN_O,
  output logic             PERIPH_CLK_EN_O,
  output logic             TIC_CLK_EN_O,
  // Pin control
  output logic             ALE_LEVEL_O,
  output logic             ALE_FORCE_O,
  output logic             PROG_STROBE_LEVEL_O,
  output logic             PROG_STROBE_FORCE_O,
  output logic             PORT_HOLD_O,
  output logic             DAC_HOLD_O,
  output logic             DAC_OE_O,
  // Core resume request
  output logic             RESUME_O
);

  psm_state_t s_q;                      // Registered state
  psm_state_t s_d;                      // Next state
  logic       wr_en;                    // APB write accepted
  logic       rd_en;                    // APB read accepted
  logic       mapped;                   // Address hits a register
  logic       pd_wake;                  // Qualified powerdown wake

  // Address decode used by read and write paths
  function automatic logic is_addr(input logic [11:0] a, input logic [11:0] r);
    is_addr = (a == r);
  endfunction : is_addr

  // A write lands at the edge that closes the access phase
  assign wr_en  = PSEL_I & PENABLE_I & PWRITE_I;
  // Read data is captured in the setup cycle so that the registered
  // value already stands during the whole access phase, when the
  // master takes it at the edge that samples ready high
  assign rd_en  = PSEL_I & ~PENABLE_I & ~PWRITE_I;
  assign mapped = is_addr(PADDR_I, `PSM_PWR_CTRL_ADDR) |
                  is_addr(PADDR_I, `PSM_PLL_CTRL_ADDR) |
                  is_addr(PADDR_I, `PSM_STATUS_ADDR);

  // Powerdown wake qualification on synchronised sources
  assign pd_wake = s_q.sync2.time_interval_counter |
                   (s_q.sync2.serial & s_q.pwr_ctrl[`PSM_SER_WAKE_BIT]) |
                   (s_q.sync2.ext0 & s_q.pwr_ctrl[`PSM_EXTERNAL_INTERRUPT_ZERO_WAKE_BIT]);

  // Next-state logic
  always_comb begin
    s_d        = s_q;
    s_d.resume = 1'b0;
    // Two-stage synchroniser for wake sources
    s_d.sync1  = '{time_interval_counter: TIC_IRQ_I, serial: SERIAL_IRQ_I, ext0: EXT_EXTERNAL_INTERRUPT_ZERO_IRQ_I,
                   any_en: ANY_EN_IRQ_I};
    s_d.sync2  = s_q.sync1;
    // Register writes
    if (wr_en && is_addr(PADDR_I, `PSM_PWR_CTRL_ADDR)) begin
      s_d.pwr_ctrl = PWDATA_I[3:0];
    end
    if (wr_en && is_addr(PADDR_I, `PSM_PLL_CTRL_ADDR)) begin
      s_d.oscillator_powerdown_bit = PWDATA_I[`PSM_OSCILLATOR_POWERDOWN_BIT_BIT];
    end
    // Mode sequencing; the core clock stays gated while not normal,
    // so every core register keeps its value through idle
    // Powerdown has priority when both mode bits are written at once
    unique case (s_q.mode)
      PSM_NORMAL: begin
        if (s_q.pwr_ctrl[`PSM_PDOWN_BIT]) begin
          s_d.mode = PSM_PDOWN;
        end else if (s_q.pwr_ctrl[`PSM_IDLE_BIT]) begin
          s_d.mode = PSM_IDLE;
        end
      end
      PSM_IDLE: begin
        // Only an enabled interrupt ends idle; wake enables are kept
        if (s_q.sync2.any_en) begin
          s_d.mode   = PSM_NORMAL;
          s_d.resume = 1'b1;
          s_d.pwr_ctrl[`PSM_IDLE_BIT] = 1'b0;
        end
      end
      PSM_PDOWN: begin
        // Interval counter always wakes, serial and ext0 when enabled
        if (pd_wake) begin
          s_d.mode   = PSM_NORMAL;
          s_d.resume = 1'b1;
          s_d.pwr_ctrl[`PSM_PDOWN_BIT] = 1'b0;
          s_d.pwr_ctrl[`PSM_IDLE_BIT]  = 1'b0;
        end
      end
      // Illegal one-hot code recovers to normal
      default: s_d.mode = PSM_NORMAL;
    endcase
    // Read data capture
    if (rd_en) begin
      if (is_addr(PADDR_I, `PSM_PWR_CTRL_ADDR)) begin
        s_d.prdata = {28'h0000000, s_q.pwr_ctrl};
      end else if (is_addr(PADDR_I, `PSM_PLL_CTRL_ADDR)) begin
        s_d.prdata = {31'h00000000, s_q.oscillator_powerdown_bit};
      end else if (is_addr(PADDR_I, `PSM_STATUS_ADDR)) begin
        s_d.prdata = {29'h00000000, s_q.mode};
      end else begin
        s_d.prdata = `PSM_RD_NONE;
      end
    end
  end

  // State register, synchronous active-low reset
  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      s_q <= '{mode: PSM_NORMAL, pwr_ctrl: `PSM_PWR_CTRL_RST,
               oscillator_powerdown_bit: `PSM_PLL_CTRL_RST, resume: 1'b0, prdata: 32'h00000000,
               sync1: '0, sync2: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // APB answers: zero wait states, error on unmapped address
  // An unmapped write changes nothing and an unmapped read returns zero
  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = PSEL_I & PENABLE_I & ~mapped;
  always_comb begin
    PRDATA_O = s_q.prdata;
  end

  // Clock gating per mode
  assign OSC_EN_O        = (s_q.mode != PSM_PDOWN) | ~s_q.oscillator_powerdown_bit;
  assign PLL_EN_O        = (s_q.mode != PSM_PDOWN);
  assign CORE_CLK_EN_O   = (s_q.mode == PSM_NORMAL);
  assign PERIPH_CLK_EN_O = (s_q.mode != PSM_PDOWN);
  assign TIC_CLK_EN_O    = OSC_EN_O;

  // Pin behaviour per mode
  assign ALE_FORCE_O         = (s_q.mode != PSM_NORMAL);
  assign ALE_LEVEL_O         = (s_q.mode == PSM_IDLE);
  assign PROG_STROBE_FORCE_O = (s_q.mode != PSM_NORMAL);
  assign PROG_STROBE_LEVEL_O = (s_q.mode == PSM_IDLE);
  assign PORT_HOLD_O         = (s_q.mode != PSM_NORMAL);
  assign DAC_HOLD_O          = (s_q.mode == PSM_IDLE);
  assign DAC_OE_O            = (s_q.mode != PSM_PDOWN);
  assign RESUME_O            = s_q.resume;

  // Assertions
  property p_enter_idle;
    @(posedge SYS_CLK_I) disable iff (!RSTN_I)
      (s_q.mode == PSM_NORMAL && s_q.pwr_ctrl == 4'h1) |=> (s_q.mode == PSM_IDLE);
  endproperty
  a_enter_idle: assert property (p_enter_idle) else $error("idle not entered");

  property p_idle_clocks;
    @(posedge SYS_CLK_I) disable iff (!RSTN_I)
      (s_q.mode == PSM_IDLE) |-> (OSC_EN_O && !CORE_CLK_EN_O && PERIPH_CLK_EN_O);
  endproperty
  a_idle_clocks: assert property (p_idle_clocks) else $error("idle clocks wrong");

  property p_idle_pins;
    @(posedge SYS_CLK_I) disable iff (!RSTN_I)
      (s_q.mode == PSM_IDLE) |-> (ALE_LEVEL_O && PROG_STROBE_LEVEL_O && DAC_OE_O);
  endproperty
  a_idle_pins: assert property (p_idle_pins) else $error("idle pins wrong");

  property p_idle_wake;
    @(posedge SYS_CLK_I) disable iff (!RSTN_I)
      (s_q.mode == PSM_IDLE && s_q.sync2.any_en) |=> (s_q.mode == PSM_NORMAL && RESUME_O);
  endproperty
  a_idle_wake: assert property (p_idle_wake) else $error("idle wake missed");

  property p_pd_pins;
    @(posedge SYS_CLK_I) disable iff (!RSTN_I)
      (s_q.mode == PSM_PDOWN) |-> (!ALE_LEVEL_O && !DAC_OE_O && PORT_HOLD_O && !PLL_EN_O);
  endproperty
  a_pd_pins: assert property (p_pd_pins) else $error("powerdown outputs wrong");

  property p_pd_osc;
    @(posedge SYS_CLK_I) disable iff (!RSTN_I)
      (s_q.mode == PSM_PDOWN) |-> (OSC_EN_O == !s_q.oscillator_powerdown_bit && TIC_CLK_EN_O == OSC_EN_O);
  endproperty
  a_pd_osc: assert property (p_pd_osc) else $error("oscillator select wrong");

  property p_tic_wake;
    @(posedge SYS_CLK_I) disable iff (!RSTN_I)
      (s_q.mode == PSM_PDOWN && s_q.sync2.time_interval_counter) |=> (s_q.mode == PSM_NORMAL && RESUME_O);
  endproperty
  a_tic_wake: assert property (p_tic_wake) else $error("tic wake missed");

  property p_ser_block;
    @(posedge SYS_CLK_I) disable iff (!RSTN_I)
      (s_q.mode == PSM_PDOWN && !s_q.sync2.time_interval_counter && !s_q.sync2.ext0 &&
       !s_q.pwr_ctrl[`PSM_SER_WAKE_BIT]) |=> (s_q.mode == PSM_PDOWN);
  endproperty
  a_ser_block: assert property (p_ser_block) else $error("unqualified wake");

  property p_ext0_wake;
    @(posedge SYS_CLK_I) disable iff (!RSTN_I)
      (s_q.mode == PSM_PDOWN && s_q.sync2.ext0 && s_q.pwr_ctrl[`PSM_EXTERNAL_INTERRUPT_ZERO_WAKE_BIT])
        |=> (s_q.mode == PSM_NORMAL);
  endproperty
  a_ext0_wake: assert property (p_ext0_wake) else $error("ext0 wake missed");

  property p_reset_normal;
    @(posedge SYS_CLK_I) !RSTN_I |=> (s_q.mode == PSM_NORMAL && s_q.pwr_ctrl == 4'h0);
  endproperty
  a_reset_normal: assert property (p_reset_normal) else $error("reset not normal");

  // Powerdown bit written in normal mode enters powerdown
  property p_enter_pd;
    @(posedge SYS_CLK_I) disable iff (!RSTN_I)
      (s_q.mode == PSM_NORMAL && s_q.pwr_ctrl[`PSM_PDOWN_BIT]) |=> (s_q.mode == PSM_PDOWN);
  endproperty
  a_enter_pd: assert property (p_enter_pd) else $error("powerdown not entered");

  // Idle without a wake request stays idle, core clock held
  property p_idle_hold;
    @(posedge SYS_CLK_I) disable iff (!RSTN_I)
      (s_q.mode == PSM_IDLE && !s_q.sync2.any_en) |=> (s_q.mode == PSM_IDLE && !CORE_CLK_EN_O);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("idle left early");

  // Ports and DAC hold their levels while idle
  property p_idle_hold_pins;
    @(posedge SYS_CLK_I) disable iff (!RSTN_I)
      (s_q.mode == PSM_IDLE) |-> (PORT_HOLD_O && DAC_HOLD_O && ALE_FORCE_O && PROG_STROBE_FORCE_O);
  endproperty
  a_idle_hold_pins: assert property (p_idle_hold_pins) else $error("idle hold wrong");

  // Core and peripheral clocks are off in powerdown
  property p_pd_clocks;
    @(posedge SYS_CLK_I) disable iff (!RSTN_I)
      (s_q.mode == PSM_PDOWN) |-> (!CORE_CLK_EN_O && !PERIPH_CLK_EN_O && !PROG_STROBE_LEVEL_O);
  endproperty
  a_pd_clocks: assert property (p_pd_clocks) else $error("powerdown clocks wrong");

  // Interval counter clock runs whenever the chip is not in powerdown
  property p_tic_clock;
    @(posedge SYS_CLK_I) disable iff (!RSTN_I)
      (s_q.mode != PSM_PDOWN) |-> TIC_CLK_EN_O;
  endproperty
  a_tic_clock: assert property (p_tic_clock) else $error("tic clock stopped");

  // Enabled serial request ends powerdown with a resume pulse
  property p_ser_wake;
    @(posedge SYS_CLK_I) disable iff (!RSTN_I)
      (s_q.mode == PSM_PDOWN && s_q.sync2.serial && s_q.pwr_ctrl[`PSM_SER_WAKE_BIT])
        |=> (s_q.mode == PSM_NORMAL && RESUME_O);
  endproperty
  a_ser_wake: assert property (p_ser_wake) else $error("serial wake missed");

  // Resume request lasts a single cycle
  property p_resume_pulse;
    @(posedge SYS_CLK_I) disable iff (!RSTN_I)
      RESUME_O |=> !RESUME_O;
  endproperty
  a_resume_pulse: assert property (p_resume_pulse) else $error("resume too long");

  // Coverage of main scenarios
  c_idle_cycle: cover property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
    s_q.mode == PSM_IDLE ##[1:50] s_q.mode == PSM_NORMAL);
  c_pd_tic: cover property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
    s_q.mode == PSM_PDOWN && s_q.sync2.time_interval_counter);
  c_pd_ser: cover property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
    s_q.mode == PSM_PDOWN && pd_wake && s_q.sync2.serial);
  c_pd_ext0: cover property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
    s_q.mode == PSM_PDOWN && pd_wake && s_q.sync2.ext0);

endmodule : psm_ctrl

// [psm_pkg.sv]
// Types shared by the power-saving controller
package psm_pkg;
  // Operating modes, one-hot
  typedef enum logic [2:0] {
    PSM_NORMAL = 3'h1,
    PSM_IDLE   = 3'h2,
    PSM_PDOWN  = 3'h4
  } psm_mode_t;

  // Wake-up request sources
  typedef struct packed {
    logic time_interval_counter;                          // Time interval counter interrupt
    logic serial;                       // I2C/SPI interrupt
    logic ext0;                         // External interrupt zero
    logic any_en;                       // Any enabled interrupt
  } psm_wake_t;

  // Whole controller state
  typedef struct packed {
    psm_mode_t  mode;
    logic [3:0] pwr_ctrl;
    logic       oscillator_powerdown_bit;
    logic       resume;
    logic [31:0] prdata;
    psm_wake_t  sync1;
    psm_wake_t  sync2;
  } psm_state_t;
endpackage : psm_pkg

// [psm_wake_model.sv]
// Far-side model: interrupt sources that wake the power controller
`timescale 1ns/1ps
module psm_wake_model
  import psm_pkg::*;
(
  // Clock and reset
  input  wire logic      clk_i,
  input  wire logic      rstn_i,
  // Stimulus from the bench
  input  wire psm_wake_t raise_i,   // One-cycle pulse raises a source
  input  wire logic      clr_i,     // Withdraws every pending source
  // Core side
  input  wire logic      resume_i,  // Core woke and serviced the sources
  output psm_wake_t      irq_o      // Pending request levels
);
  psm_wake_t pend_q;                // Latched requests
  // Level sources stay up until serviced or withdrawn
  always_ff @(posedge clk_i) begin
    if (!rstn_i || clr_i || resume_i) begin
      pend_q <= '0;
    end else begin
      pend_q <= psm_wake_t'(pend_q | raise_i);
    end
  end
  assign irq_o = pend_q;
endmodule : psm_wake_model
